// file: hw/posted_access_sync_status.sv
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "rtc_sync_consts.svh"

// Behaviour
// - The status register exists only in the second clock instance; in the first it reads as its reset value.
// - Status is kept only for capture and strobe-control targets that live in the always-on slow domain.
// - Bit 15 shows whether a posted write to the strobe timing mask register is visible, low while pending.
// - Bits 14, 13 and 12 show whether a read of capture channel 4, 3 or 2 has updated its unread flag.
// - Bit 10 shows whether a full 47-bit read of capture channel 0 has updated its unread flag.
// - A read-sync bit reads 0 while the read's effects are not visible and 1 once they are.
// - Bits 9 down to 6 show whether a posted write to strobe channel 4 down to 1 is visible.
// - Bit 4 shows whether a posted write to the strobe mask register is visible.
// - A write-sync bit reads 1 once the write's results are visible and 0 while it propagates.
module posted_access_sync_status #(
   parameter bit IS_SECOND_INSTANCE = 1'b1,
   parameter int unsigned SLOW_DIV = `SYS_FREQ_HZ / `SLOW_FREQ_HZ
) (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic i_hready,
   input wire logic [31:0] i_hwdata,
   input wire logic [`NUM_TARGETS-1:0] i_post_issue,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   output logic [`NUM_TARGETS-1:0] o_synced
);

   localparam int DIV_W = $clog2(SLOW_DIV + 1);

   rtc_sync_pkg::ahb_phase_t phase_r;
   logic [DIV_W-1:0] div_r;
   logic slow_tick;
   logic [`NUM_TARGETS-1:0] sw_post;
   logic [`NUM_TARGETS-1:0] issue;
   rtc_sync_pkg::target_vec_t synced;
   logic [`STATUS_W-1:0] status_word;
   logic [31:0] rdata_nxt;
   logic [31:0] rdata_r;
   logic [`NUM_TARGETS-1:0] post_last_r;
   logic [11:0] req_addr;
   logic addr_take;

   // Places the flag vector into the status word; unlisted bits stay zero
   function automatic logic [`STATUS_W-1:0] pack_status(input rtc_sync_pkg::target_vec_t f);
      logic [`STATUS_W-1:0] w;
      w = '0;
      w[`BIT_TIMING_MASK] = f.timing_mask;
      w[`BIT_IC4] = f.ic4;
      w[`BIT_IC3] = f.ic3;
      w[`BIT_IC2] = f.ic2;
      w[`BIT_IC0] = f.ic0;
      w[`BIT_SS4] = f.ss4;
      w[`BIT_SS3] = f.ss3;
      w[`BIT_SS2] = f.ss2;
      w[`BIT_SS1] = f.ss1;
      w[`BIT_MASK] = f.mask;
      return w;
   endfunction

   // Slow-domain tick; one cycle every SLOW_DIV system clocks
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         div_r <= '0;
      end else if (div_r == DIV_W'(SLOW_DIV - 1)) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   assign slow_tick = (div_r == DIV_W'(SLOW_DIV - 1));

   assign addr_take = i_hsel && i_htrans[`HTRANS_ACTIVE_BIT] && i_hready;
   assign req_addr = i_haddr[11:0];

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         phase_r <= '0;
      end else if (i_hready) begin
         phase_r.valid <= addr_take;
         phase_r.write <= i_hwrite;
         phase_r.addr <= req_addr;
      end
   end

   // Software may post accesses itself through the issue register
   assign sw_post = (phase_r.valid && phase_r.write && phase_r.addr == `OFS_POST_ISSUE) ?
                    i_hwdata[`NUM_TARGETS-1:0] : '0;

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         post_last_r <= `POST_RESET;
      end else if (sw_post != '0) begin
         post_last_r <= sw_post;
      end
   end

   assign issue = IS_SECOND_INSTANCE ? (i_post_issue | sw_post) : '0;

   genvar g;
   generate
      for (g = 0; g < `NUM_TARGETS; g++) begin : g_trk
         posted_sync_tracker u_trk (
            .i_clk_sys(i_clk_sys),
            .i_srst(i_srst),
            .i_issue(issue[g]),
            .i_slow_tick(slow_tick),
            .o_synced(synced[g])
         );
      end
   endgenerate

   assign status_word = IS_SECOND_INSTANCE ? pack_status(synced) : `STATUS_RESET;

   always_comb begin
      rdata_nxt = '0;
      unique case (req_addr)
         `OFS_SYNC_STATUS: rdata_nxt = {16'h0000, status_word};
         `OFS_POST_ISSUE: rdata_nxt = {22'h0, post_last_r};
         `OFS_INSTANCE_ID: rdata_nxt = {31'h0, IS_SECOND_INSTANCE};
         default: rdata_nxt = '0;
      endcase
   end

   // Read data is loaded at the address phase so it stands for the whole data phase
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         rdata_r <= '0;
      end else if (addr_take && !i_hwrite) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign o_hrdata = rdata_r;
   assign o_hreadyout = 1'b1;
   assign o_hresp = `HRESP_OKAY;
   assign o_synced = synced;

endmodule

// file: hw/posted_sync_tracker.sv
`timescale 1ns/1ps
`include "rtc_sync_consts.svh"

module posted_sync_tracker (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic i_issue,
   input wire logic i_slow_tick,
   output logic o_synced
);

   rtc_sync_pkg::trk_state_t state_r;
   logic [`SYNC_CNT_W-1:0] cnt_r;
   logic synced_r;

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         state_r <= rtc_sync_pkg::TRK_IDLE;
      end else if (i_issue) begin
         state_r <= rtc_sync_pkg::TRK_COUNT;
      end else begin
         unique case (state_r)
            rtc_sync_pkg::TRK_IDLE: begin
               state_r <= rtc_sync_pkg::TRK_IDLE;
            end
            rtc_sync_pkg::TRK_COUNT: begin
               if (i_slow_tick && cnt_r == `SYNC_CNT_W'(`SYNC_TICKS - 1)) begin
                  state_r <= rtc_sync_pkg::TRK_DONE;
               end
            end
            rtc_sync_pkg::TRK_DONE: begin
               state_r <= rtc_sync_pkg::TRK_IDLE;
            end
            default: begin
               state_r <= rtc_sync_pkg::TRK_IDLE;
            end
         endcase
      end
   end

   // Ticks counted only while the access is in flight; a new issue restarts
   always_ff @(posedge i_clk_sys) begin
      if (i_srst || i_issue) begin
         cnt_r <= '0;
      end else if (state_r == rtc_sync_pkg::TRK_COUNT && i_slow_tick) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // set wins clear
   // A restart under a completing access loses to the set, so the flag drops one cycle later
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         synced_r <= 1'b1;
      end else if (state_r == rtc_sync_pkg::TRK_DONE) begin
         synced_r <= 1'b1;
      end else if (i_issue || state_r == rtc_sync_pkg::TRK_COUNT) begin
         synced_r <= 1'b0;
      end
   end

   assign o_synced = synced_r;

endmodule

// file: include/rtc_sync_consts.svh
`ifndef RTC_SYNC_CONSTS_SVH
`define RTC_SYNC_CONSTS_SVH

// Register byte offsets
`define OFS_SYNC_STATUS 12'h000
`define OFS_POST_ISSUE 12'h004
`define OFS_INSTANCE_ID 12'h008

// Status field positions
`define BIT_TIMING_MASK 15
`define BIT_IC4 14
`define BIT_IC3 13
`define BIT_IC2 12
`define BIT_IC0 10
`define BIT_SS4 9
`define BIT_SS3 8
`define BIT_SS2 7
`define BIT_SS1 6
`define BIT_MASK 4

// Number of tracked posted-access targets
`define NUM_TARGETS 10
// Status register width and reset value (every target idle and visible)
`define STATUS_W 16
`define STATUS_RESET 16'hf7d0
// Post-issue register: one bit per tracked target, low bits
`define POST_RESET 10'h000

// Always-on domain rate and system clock rate
`define SLOW_FREQ_HZ 32768
`define SYS_FREQ_HZ 250000000
// Slow-domain ticks from posting to visibility (cross in, act, cross back)
`define SYNC_TICKS 3
`define SYNC_CNT_W 2

// AHB transfer type bit that marks an active transfer
`define HTRANS_ACTIVE_BIT 1
`define HRESP_OKAY 1'b0

`endif

// file: include/rtc_sync_pkg.sv
package rtc_sync_pkg;

   // Address phase captured for the following data phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [11:0] addr;
   } ahb_phase_t;

   // One flag per tracked target, in status-bit order, high to low
   typedef struct packed {
      logic timing_mask;
      logic ic4;
      logic ic3;
      logic ic2;
      logic ic0;
      logic ss4;
      logic ss3;
      logic ss2;
      logic ss1;
      logic mask;
   } target_vec_t;

   typedef enum logic [1:0] {
      TRK_IDLE = 2'b00,
      TRK_COUNT = 2'b01,
      TRK_DONE = 2'b11
   } trk_state_t;

endpackage

// file: testbench/cpu_bus_model.sv
`timescale 1ns/1ps
module cpu_bus_model (
   input logic i_clk,
   input logic i_hready,
   input logic [31:0] i_hrdata,
   output logic o_hsel = 1'b0,
   output logic [31:0] o_haddr = '0,
   output logic [1:0] o_htrans = '0,
   output logic o_hwrite = 1'b0,
   output logic [31:0] o_hwdata = '0
);
   int n_hang = 0;
   task step;
      int k;
      k = 0;
      do begin
         @(posedge i_clk);
         k++;
      end while (i_hready !== 1'b1 && k < 16);
      if (k >= 16) n_hang++;
   endtask
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      o_hsel <= 1'b1;
      o_haddr <= a;
      o_hwrite <= w;
      o_htrans <= 2'b10;
      // Stale write data never repeats
      o_hwdata <= ~o_hwdata;
      step();
      o_htrans <= 2'b00;
      o_hwdata <= d;
      step();
      r = i_hrdata;
   endtask
endmodule

// file: testbench/posted_access_sync_status_tb.sv
`timescale 1ns/1ps
`include "rtc_sync_consts.svh"
module posted_access_sync_status_tb;
   logic i_clk_sys = 1'b0;
   logic i_srst = 1'b1;
   logic [9:0] i_post_issue = '0;
   logic [31:0] r;
   logic [31:0] v;
   logic [9:0] exp_s;
   logic [9:0] exp_p = '0;
   int n_fail = 0;
   int tests_run = 0;
   int seed = 86809;
   wire i_hsel, i_hwrite, o_hreadyout, o_hresp;
   wire [1:0] i_htrans;
   wire [31:0] i_haddr, i_hwdata, o_hrdata, rd0;
   wire [9:0] o_synced, sy0;
   initial forever #2 i_clk_sys = ~i_clk_sys;
   cpu_bus_model i_cpu_bus_model (.i_clk(i_clk_sys), .i_hready(o_hreadyout), .i_hrdata(o_hrdata),
      .o_hsel(i_hsel), .o_haddr(i_haddr), .o_htrans(i_htrans), .o_hwrite(i_hwrite), .o_hwdata(i_hwdata));
   posted_access_sync_status #(.SLOW_DIV(4)) i_posted_access_sync_status (.i_clk_sys, .i_srst, .i_hsel,
      .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'b010), .i_hready(o_hreadyout), .i_hwdata, .i_post_issue,
      .o_hreadyout, .o_hresp, .o_hrdata, .o_synced);
   // Twin built as the first instance sees the same traffic
   posted_access_sync_status #(.IS_SECOND_INSTANCE(1'b0), .SLOW_DIV(4)) i_posted_access_sync_status_first (
      .i_clk_sys, .i_srst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'b010), .i_hready(o_hreadyout),
      .i_hwdata, .i_post_issue, .o_hreadyout(), .o_hresp(), .o_hrdata(rd0), .o_synced(sy0));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task rw(input logic w, input logic [31:0] a, input logic [31:0] d);
      i_cpu_bus_model.xfer(w, a, d, r);
      if (i_cpu_bus_model.n_hang != 0) begin
         complete_run();
      end
   endtask
   function automatic logic [31:0] img(input logic [9:0] s);
      return {16'h0, s[9:6], 1'b0, s[5:1], 1'b0, s[0], 4'h0};
   endfunction
   task complete_run;
      n_fail += i_cpu_bus_model.n_hang;
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      complete_run();
   end
   initial begin
      repeat (4) @(posedge i_clk_sys);
      i_srst <= 1'b0;
      @(posedge i_clk_sys);
      exp_s = 10'h3ff;
      rw(1'b1, `OFS_SYNC_STATUS, 32'hffffffff);
      rw(1'b0, `OFS_SYNC_STATUS, 0);
      chk(r, `STATUS_RESET);
      rw(1'b0, 32'hc, 0);
      chk(r, 0);
      rw(1'b0, `OFS_INSTANCE_ID, 0);
      chk(r, 1);
      for (int g = 0; g < 14; g++) begin
         v = (g < 10) ? 32'h1 << g : $random(seed);
         if (g[0]) begin
            i_post_issue <= v[9:0];
            @(posedge i_clk_sys);
            i_post_issue <= '0;
         end else begin
            rw(1'b1, `OFS_POST_ISSUE, v);
            if (v[9:0] != 0) begin
               exp_p = v[9:0];
            end
         end
         repeat (2) @(posedge i_clk_sys);
         exp_s = exp_s & ~v[9:0];
         rw(1'b0, `OFS_SYNC_STATUS, 0);
         chk(r, img(exp_s));
         chk(sy0, 10'h3ff);
         repeat (24) @(posedge i_clk_sys);
         exp_s = 10'h3ff;
         rw(1'b0, `OFS_SYNC_STATUS, 0);
         chk(r, img(exp_s));
         chk(rd0, `STATUS_RESET);
         chk({o_hreadyout, o_hresp}, {1'b1, `HRESP_OKAY});
         rw(1'b0, `OFS_POST_ISSUE, 0);
         chk(r, exp_p);
         $display("test %0d done", g);
      end
      // A reissue while pending restarts the count
      i_post_issue <= 10'h001;
      @(posedge i_clk_sys);
      i_post_issue <= '0;
      repeat (5) @(posedge i_clk_sys);
      i_post_issue <= 10'h001;
      @(posedge i_clk_sys);
      i_post_issue <= '0;
      repeat (7) @(posedge i_clk_sys);
      rw(1'b0, `OFS_SYNC_STATUS, 0);
      chk(r, img(10'h3fe));
      repeat (24) @(posedge i_clk_sys);
      rw(1'b0, `OFS_SYNC_STATUS, 0);
      chk(r, img(10'h3ff));
      $display("test reissue done");
      complete_run();
   end
endmodule

// file: testbench/sync_properties.sv
`timescale 1ns/1ps
module sync_properties #(
   parameter bit IS_SECOND_INSTANCE = 1'b1,
   parameter int unsigned SLOW_DIV = 4
) (
   input logic i_clk_sys,
   input logic i_srst,
   input logic i_hsel,
   input logic [31:0] i_haddr,
   input logic [1:0] i_htrans,
   input logic i_hwrite,
   input logic i_hready,
   input logic [9:0] i_post_issue,
   input logic [31:0] o_hrdata,
   input logic [9:0] o_synced
);
   logic rd;
   logic [31:0] img;
   logic [9:0] hit;
   assign rd = i_hsel & i_htrans[1] & i_hready & ~i_hwrite;
   // Only targets that were visible when reissued must drop
   assign hit = i_post_issue & o_synced;
   assign img = {16'h0, o_synced[9:6], 1'b0, o_synced[5:1], 1'b0, o_synced[0], 4'h0};
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   a_status_image: assert property (rd && i_haddr[11:0] == 12'h0 ##1 $stable(o_synced) |-> o_hrdata == img)
      else $error("bad status");
   a_unlisted_zero: assert property (rd && i_haddr[11:0] == 12'hc |=> o_hrdata == 32'h0)
      else $error("unmapped nonzero");
   a_instance_id: assert property (rd && i_haddr[11:0] == 12'h8 |=> o_hrdata == 32'(IS_SECOND_INSTANCE))
      else $error("bad id");
   a_first_ignores: assert property (!IS_SECOND_INSTANCE |-> o_synced == 10'h3ff)
      else $error("first instance flag low");
   a_issue_clears: assert property (IS_SECOND_INSTANCE && hit != 0 |=>
      (o_synced & $past(hit)) == 0) else $error("flag not cleared");
   a_timing_pending: assert property ($fell(o_synced[9]) |-> !o_synced[9] [*4])
      else $error("flag rose early");
   a_capture_bound: assert property ($fell(o_synced[5]) |-> !o_synced[5] [*8] ##[1:12] o_synced[5])
      else $error("capture flag late");
   a_mask_bound: assert property ($fell(o_synced[0]) |-> ##[8:20] o_synced[0])
      else $error("mask flag late");
   c_read: cover property (rd && i_haddr[11:0] == 12'h0);
   c_fall: cover property ($fell(o_synced[5]));
   c_rise: cover property ($rose(o_synced[0]));
endmodule
bind posted_access_sync_status sync_properties #(.IS_SECOND_INSTANCE(IS_SECOND_INSTANCE), .SLOW_DIV(SLOW_DIV))
   i_sync_properties (.i_clk_sys, .i_srst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hready, .i_post_issue,
   .o_hrdata, .o_synced);
